// File: hw/uart_abd_pkg.sv
// Constants, register map and carrier types for the autobaud, wake and break serial extension
// Notes on behaviour
// - Autobaud times a 55h sync character's edges
// - Enable starts calibration; receiver held idle meanwhile
// - Counting starts at first rise after start
// - Fifth rise stores count, clears enable, flags
// - Receive flag clears on data read; discard value
// - Divisor pair counts as one 16-bit counter
// - Calibration clock is base rate divided by eight
// - Counter starts at one; software subtracts one
// - With wake enabled, calibrate byte after break
// - Counter overflow sets overflow and receive flags
// - Keeps counting; idle flag low until fifth
// - Fifth rise sets receive flag again
// - Wake mode disables reception, watches falling edge
// - Wake event sets receive flag; read clears
// - Rise ending break clears wake enable bit
// - Non-zero character: first low is wake event
// - Break is start, twelve zeros, stop
// - Data write with break and enable sends break
// - Break end clears bit, then sends buffer
package uart_abd_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W = 8;                // Byte address bits seen by the slave
	localparam int unsigned DATA_W = 32;               // Bus data width

	// Register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00; // Control bits
	localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h04; // Status flags
	localparam logic [ADDR_W-1:0] DIVISOR_OFS = 8'h08; // Rate divisor pair, high:low
	localparam logic [ADDR_W-1:0] RXDATA_OFS  = 8'h0c; // Receive data, read clears flag
	localparam logic [ADDR_W-1:0] TXDATA_OFS  = 8'h10; // Transmit data

	// Control field positions
	localparam int unsigned CTRL_AUTOBAUD_ENABLE = 0;            // autobaud_enable
	localparam int unsigned CTRL_WUE   = 1;            // wake_on_break_enable
	localparam int unsigned CTRL_SEND_BREAK = 2;            // send_break
	localparam int unsigned CTRL_TRANSMIT_ENABLE  = 3;            // transmit_enable
	localparam int unsigned CTRL_WIDE  = 4;            // wide_rate_select
	localparam int unsigned CTRL_HIGH  = 5;            // high_rate_select

	// Status field positions
	localparam int unsigned STAT_RECEIVE_INT_FLAG  = 0;            // receive_int_flag
	localparam int unsigned STAT_IDLE  = 1;            // receiver_idle_flag
	localparam int unsigned STAT_SHIFT_EMPTY_FLAG  = 2;            // shift_empty_flag
	localparam int unsigned STAT_TXBE  = 3;            // transmit_buffer_empty_flag
	localparam int unsigned STAT_OVF   = 4;            // autobaud_overflow_flag, write 1 clears

	// Rate generator terminal counts (divide by 64, 16, 4)
	localparam logic [5:0] BASE_MAX_SLOW = 6'h3f;      // Select pair 00
	localparam logic [5:0] BASE_MAX_MID  = 6'h0f;      // Select pairs 01 and 10
	localparam logic [5:0] BASE_MAX_FAST = 6'h03;      // Select pair 11
	localparam logic [2:0] ABD_PRE_MAX   = 3'h7;       // Calibration clock is base over eight

	// Calibration figures
	localparam logic [15:0] ABD_START   = 16'h0001;    // Counter starts at one
	localparam logic [2:0]  SYNC_RISES  = 3'h5;        // Rising edges in a 55h sync character
	localparam logic [15:0] DIV_RESET   = 16'h0000;    // Divisor after reset

	// Transmit frame lengths
	localparam logic [3:0]  DATA_FRAME_BITS  = 4'ha;   // Start, eight data, stop
	localparam logic [3:0]  BREAK_FRAME_BITS = 4'he;   // Start, twelve zeros, stop
	localparam logic [11:0] BREAK_ZEROS      = 12'h000;// Body of a break

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Calibration states, Gray order along the usual path
	typedef enum logic [1:0] {
		AB_IDLE       = 2'h0,
		AB_WAIT_START = 2'h1,
		AB_WAIT_RISE  = 2'h3,
		AB_COUNT      = 2'h2
	} abd_state_e;

	// Transmit states
	typedef enum logic {
		TX_IDLE  = 1'b0,
		TX_SHIFT = 1'b1
	} tx_state_e;

	// Master to slave signals of the register bus
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axil_req_s;

	// Slave to master signals of the register bus
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} axil_rsp_s;

endpackage

// File: hw/uart_abd.sv
// Autobaud calibration, wake on break and break transmission with a register bus slave
`timescale 1ns/1ns

module uart_abd
	import uart_abd_pkg::*;
(
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      rst_n,
	// Register bus
	input  wire axil_req_s bus_req,
	output axil_rsp_s      bus_rsp,
	// Serial lines
	input  wire logic      receive_line,
	output logic           transmit_line
);

	// Whole state of the block in one record
	typedef struct packed {
		// Control bits
		logic              autobaud_enable;
		logic              wake_on_break_enable;
		logic              send_break;
		logic              transmit_enable;
		logic              wide_rate_select;
		logic              high_rate_select;
		// Flags
		logic              receive_int_flag;
		logic              autobaud_overflow_flag;
		// Rate generator
		logic [5:0]        pre_cnt;
		logic [2:0]        abd_pre;
		logic [15:0]       baud_cnt;
		logic [15:0]       divisor;
		// Calibration
		abd_state_e        abd_state;
		logic [2:0]        rise_cnt;
		logic              rx_prev;
		// Transmitter
		tx_state_e         tx_state;
		logic [13:0]       tx_shift;
		logic [3:0]        tx_left;
		logic              tx_is_break;
		logic              tx_low;
		logic [7:0]        tx_buf;
		logic              tx_buf_full;
		// Bus answers
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} state_s;

	state_s s_reg;                  // Registered state
	state_s s_next;                 // Next state

	// Decoded helpers
	logic [5:0]  base_max;          // Terminal count of the base prescaler
	logic        base_tick;         // One pulse per base clock period
	logic        abd_tick;          // One pulse per calibration clock period
	logic        bit_tick;          // One pulse per transmit bit period
	logic [15:0] divisor_eff;       // Divisor as the transmitter uses it
	logic        rx_rise;           // Receive line went high
	logic        rx_fall;           // Receive line went low
	logic        wr_go;             // Write address and data taken together
	logic        rd_go;             // Read address taken
	logic        receive_int_flag_set;          // Hardware sets the receive flag
	logic        receive_int_flag_clr;          // Software read of receive data
	logic        ovf_set;           // Hardware sets the overflow flag
	logic        ovf_clr;           // Software clears the overflow flag
	logic        idle_flag;         // Receiver idle as software sees it
	logic [16:0] abd_sum;           // Counter plus one with carry out
	logic [31:0] ctrl_word;         // Control register read image
	logic [31:0] status_word;       // Status register read image

	// Response outputs come straight from the state; the write readies also need both request valids
	always_comb begin
		bus_rsp         = '0;
		bus_rsp.awready = wr_go;
		bus_rsp.wready  = wr_go;
		bus_rsp.bvalid  = s_reg.bvalid;
		bus_rsp.bresp   = s_reg.bresp;
		bus_rsp.arready = !s_reg.rvalid;
		bus_rsp.rvalid  = s_reg.rvalid;
		bus_rsp.rdata   = s_reg.rdata;
		bus_rsp.rresp   = s_reg.rresp;
	end

	// The line idles high, so the register holds its inverse and resets to zero
	assign transmit_line = !s_reg.tx_low;

	// Both halves must be present; taking them together keeps one write in flight
	assign wr_go = bus_req.awvalid && bus_req.wvalid && !s_reg.bvalid;
	assign rd_go = bus_req.arvalid && !s_reg.rvalid;

	// Base clock choice from the two select bits
	always_comb begin
		case ({s_reg.wide_rate_select, s_reg.high_rate_select})
			2'b00:   base_max = BASE_MAX_SLOW;
			2'b11:   base_max = BASE_MAX_FAST;
			default: base_max = BASE_MAX_MID;
		endcase
	end

	// Derived ticks and edges
	// Compare with at least so that a switch to a faster rate never strands the count
	assign base_tick   = (s_reg.pre_cnt >= base_max);
	assign abd_tick    = base_tick && (s_reg.abd_pre == ABD_PRE_MAX);
	assign divisor_eff = s_reg.wide_rate_select ? s_reg.divisor
	                                            : {8'h00, s_reg.divisor[7:0]};
	assign bit_tick    = base_tick && (s_reg.baud_cnt == divisor_eff);
	assign rx_rise     = receive_line && !s_reg.rx_prev;
	assign rx_fall     = !receive_line && s_reg.rx_prev;
	assign abd_sum     = {1'b0, s_reg.divisor} + 17'h00001;

	// Receiver is busy only while a sync character is being timed
	assign idle_flag = (s_reg.abd_state != AB_WAIT_RISE) &&
	                   (s_reg.abd_state != AB_COUNT);

	// Read images
	always_comb begin
		ctrl_word              = '0;
		ctrl_word[CTRL_AUTOBAUD_ENABLE]  = s_reg.autobaud_enable;
		ctrl_word[CTRL_WUE]    = s_reg.wake_on_break_enable;
		ctrl_word[CTRL_SEND_BREAK]  = s_reg.send_break;
		ctrl_word[CTRL_TRANSMIT_ENABLE]   = s_reg.transmit_enable;
		ctrl_word[CTRL_WIDE]   = s_reg.wide_rate_select;
		ctrl_word[CTRL_HIGH]   = s_reg.high_rate_select;
		status_word            = '0;
		status_word[STAT_RECEIVE_INT_FLAG] = s_reg.receive_int_flag;
		status_word[STAT_IDLE] = idle_flag;
		status_word[STAT_SHIFT_EMPTY_FLAG] = (s_reg.tx_state == TX_IDLE);
		status_word[STAT_TXBE] = !s_reg.tx_buf_full;
		status_word[STAT_OVF]  = s_reg.autobaud_overflow_flag;
	end

	// Next state: hardware first, then software, then the flags with set over clear
	always_comb begin
		s_next   = s_reg;
		receive_int_flag_set = 1'b0;
		ovf_set  = 1'b0;
		receive_int_flag_clr = 1'b0;
		ovf_clr  = 1'b0;

		// Free running prescalers for the base and calibration clocks
		s_next.rx_prev = receive_line;
		if (base_tick) begin
			s_next.pre_cnt = '0;
			s_next.abd_pre = s_reg.abd_pre + 3'h1;
		end else begin
			s_next.pre_cnt = s_reg.pre_cnt + 6'h01;
		end

		// Sync character timing
		case (s_reg.abd_state)
			AB_IDLE: begin
				// A pending wake holds calibration off until the break has ended
				if (s_reg.autobaud_enable && !s_reg.wake_on_break_enable) begin
					s_next.abd_state = AB_WAIT_START;
				end
			end
			AB_WAIT_START: begin
				if (!s_reg.autobaud_enable) begin
					s_next.abd_state = AB_IDLE;
				end else if (rx_fall) begin
					s_next.abd_state = AB_WAIT_RISE;
				end
			end
			AB_WAIT_RISE: begin
				if (!s_reg.autobaud_enable) begin
					s_next.abd_state = AB_IDLE;
				end else if (rx_rise) begin
					// Prescaler realigned so the first count lands a full period later
					s_next.divisor   = ABD_START;
					s_next.abd_pre   = '0;
					s_next.rise_cnt  = 3'h1;
					s_next.abd_state = AB_COUNT;
				end
			end
			AB_COUNT: begin
				if (!s_reg.autobaud_enable) begin
					// Early abort leaves the partial count; later falls look like starts
					s_next.abd_state = AB_IDLE;
				end else begin
					if (abd_tick) begin
						s_next.divisor = abd_sum[15:0];
						if (abd_sum[16]) begin
							ovf_set  = 1'b1;
							receive_int_flag_set = 1'b1;
						end
					end
					if (rx_rise) begin
						s_next.rise_cnt = s_reg.rise_cnt + 3'h1;
						if (s_reg.rise_cnt == SYNC_RISES - 3'h1) begin
							// Count stays in the divisor pair as the new rate
							s_next.autobaud_enable = 1'b0;
							receive_int_flag_set               = 1'b1;
							s_next.abd_state       = AB_IDLE;
						end
					end
				end
			end
			default: s_next.abd_state = AB_IDLE;
		endcase

		// Wake on break, only while no sync character is being timed
		if (s_reg.wake_on_break_enable && s_reg.abd_state == AB_IDLE) begin
			if (rx_fall) begin
				receive_int_flag_set = 1'b1;
			end
			if (rx_rise) begin
				s_next.wake_on_break_enable = 1'b0;
			end
		end

		// Transmit bit timing runs from the whole divisor with wide select, from its low byte otherwise
		if (s_reg.tx_state == TX_SHIFT && base_tick) begin
			s_next.baud_cnt = bit_tick ? 16'h0000 : s_reg.baud_cnt + 16'h0001;
		end

		// Transmitter
		case (s_reg.tx_state)
			TX_IDLE: begin
				if (s_reg.tx_buf_full && s_reg.transmit_enable) begin
					s_next.tx_buf_full = 1'b0;
					s_next.baud_cnt    = '0;
					s_next.tx_state    = TX_SHIFT;
					s_next.tx_low      = 1'b1;
					if (s_reg.send_break) begin
						// The written byte is dropped, zeros go out instead
						s_next.tx_shift    = {1'b0, 1'b1, BREAK_ZEROS};
						s_next.tx_left     = BREAK_FRAME_BITS;
						s_next.tx_is_break = 1'b1;
					end else begin
						s_next.tx_shift    = {5'h1f, 1'b1, s_reg.tx_buf};
						s_next.tx_left     = DATA_FRAME_BITS;
						s_next.tx_is_break = 1'b0;
					end
				end
			end
			TX_SHIFT: begin
				if (bit_tick) begin
					if (s_reg.tx_left == 4'h1) begin
						// Stop bit done; a preloaded byte follows from idle
						s_next.tx_state = TX_IDLE;
						s_next.tx_low   = 1'b0;
						if (s_reg.tx_is_break) begin
							s_next.send_break = 1'b0;
						end
					end else begin
						s_next.tx_low   = !s_reg.tx_shift[0];
						s_next.tx_shift = {1'b1, s_reg.tx_shift[13:1]};
						s_next.tx_left  = s_reg.tx_left - 4'h1;
					end
				end
			end
			default: s_next.tx_state = TX_IDLE;
		endcase

		// Bus write; a software set of a control bit beats a hardware clear
		if (s_reg.bvalid && bus_req.bready) begin
			s_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_next.bvalid = 1'b1;
			s_next.bresp  = RESP_OKAY;
			case (bus_req.awaddr)
				CTRL_OFS: begin
					if (bus_req.wstrb[0]) begin
						s_next.autobaud_enable      = bus_req.wdata[CTRL_AUTOBAUD_ENABLE];
						s_next.wake_on_break_enable = bus_req.wdata[CTRL_WUE];
						s_next.send_break           = bus_req.wdata[CTRL_SEND_BREAK];
						s_next.transmit_enable      = bus_req.wdata[CTRL_TRANSMIT_ENABLE];
						s_next.wide_rate_select     = bus_req.wdata[CTRL_WIDE];
						s_next.high_rate_select     = bus_req.wdata[CTRL_HIGH];
					end
				end
				STATUS_OFS: begin
					ovf_clr = bus_req.wstrb[0] && bus_req.wdata[STAT_OVF];
				end
				DIVISOR_OFS: begin
					// The counter owns the pair while a character is timed
					if (s_reg.abd_state != AB_COUNT) begin
						if (bus_req.wstrb[0]) begin
							s_next.divisor[7:0] = bus_req.wdata[7:0];
						end
						if (bus_req.wstrb[1]) begin
							s_next.divisor[15:8] = bus_req.wdata[15:8];
						end
					end
				end
				TXDATA_OFS: begin
					// A write to a full buffer is dropped; software watches the flag
					if (!s_reg.tx_buf_full && bus_req.wstrb[0]) begin
						s_next.tx_buf      = bus_req.wdata[7:0];
						s_next.tx_buf_full = 1'b1;
					end
				end
				RXDATA_OFS: begin
					s_next.bresp = RESP_OKAY;
				end
				default: s_next.bresp = RESP_DECERR;
			endcase
		end

		// Bus read; receive data reads back zero and clears the receive flag
		if (s_reg.rvalid && bus_req.rready) begin
			s_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = RESP_OKAY;
			case (bus_req.araddr)
				CTRL_OFS:    s_next.rdata = ctrl_word;
				STATUS_OFS:  s_next.rdata = status_word;
				DIVISOR_OFS: s_next.rdata = {16'h0000, s_reg.divisor};
				TXDATA_OFS:  s_next.rdata = '0;
				RXDATA_OFS: begin
					s_next.rdata = '0;
					receive_int_flag_clr     = 1'b1;
				end
				default: begin
					s_next.rdata = '0;
					s_next.rresp = RESP_DECERR;
				end
			endcase
		end

		// Flags: an event in the clearing cycle is kept
		if (receive_int_flag_clr) begin
			s_next.receive_int_flag = 1'b0;
		end
		if (receive_int_flag_set) begin
			s_next.receive_int_flag = 1'b1;
		end
		if (ovf_clr) begin
			s_next.autobaud_overflow_flag = 1'b0;
		end
		if (ovf_set) begin
			s_next.autobaud_overflow_flag = 1'b1;
		end
	end

	// State register; the edge detector resets to the idle level so no false rise follows
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg         <= '0;
			s_reg.divisor <= DIV_RESET;
			s_reg.rx_prev <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule

// File: bench/uart_abd_assertions.sv
// Bus handshake and serial line checks for the serial extension block
`timescale 1ns/1ns

module uart_abd_assertions
	import uart_abd_pkg::*;
(
	// Clock and reset
	input wire logic      clk,
	input wire logic      rst_n,
	// Register bus
	input wire axil_req_s bus_req,
	input wire axil_rsp_s bus_rsp,
	// Serial output
	input wire logic      transmit_line
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Requests accepted at this edge
	wire logic wr_take = bus_req.awvalid && bus_req.wvalid && bus_rsp.awready;
	wire logic rd_take = bus_req.arvalid && bus_rsp.arready;

	wr_answer_a: assert property (wr_take |=> bus_rsp.bvalid)
		else $error("write not answered next cycle");
	rd_answer_a: assert property (rd_take |=> bus_rsp.rvalid)
		else $error("read not answered next cycle");
	bresp_hold_a: assert property (bus_rsp.bvalid && !bus_req.bready |=>
		bus_rsp.bvalid && $stable(bus_rsp.bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (bus_rsp.rvalid && !bus_req.rready |=>
		bus_rsp.rvalid && $stable(bus_rsp.rdata))
		else $error("read data dropped early");
	wr_refuse_a: assert property (bus_rsp.bvalid |-> !bus_rsp.awready && !bus_rsp.wready)
		else $error("write taken while response pending");
	rd_refuse_a: assert property (bus_rsp.rvalid |-> !bus_rsp.arready)
		else $error("read taken while data pending");
	bvalid_cause_a: assert property ($rose(bus_rsp.bvalid) |-> $past(wr_take))
		else $error("write response without request");
	// The receive data word carries nothing; software discards it
	rx_discard_a: assert property (rd_take && bus_req.araddr == RXDATA_OFS |=>
		bus_rsp.rdata == '0 && bus_rsp.rresp == RESP_OKAY)
		else $error("receive data read not zero");
	unmapped_a: assert property (rd_take && bus_req.araddr > TXDATA_OFS |=>
		bus_rsp.rresp == RESP_DECERR)
		else $error("unmapped read not refused");
	tx_idle_a: assert property (!$past(rst_n) |-> transmit_line)
		else $error("transmit line not idle after reset");
endmodule

bind uart_abd uart_abd_assertions uart_abd_assertions_inst (
	.clk          (clk),
	.rst_n        (rst_n),
	.bus_req      (bus_req),
	.bus_rsp      (bus_rsp),
	.transmit_line(transmit_line)
);

// File: bench/serial_node_model.sv
// Remote serial node: drives the receive line and decodes the transmit line
`timescale 1ns/1ns

module serial_node_model (
	// Clock
	input wire logic clk,
	// Serial lines
	output logic     line_out,
	input wire logic line_in
);
	// Mark level until a frame is sent
	initial line_out = 1'b1;

	// Hold one level for a number of clocks; a long low is a break
	task automatic lvl(input logic v, input int n);
		line_out <= v;
		repeat (n) @(posedge clk);
	endtask

	// One character, start bit first, data least significant bit first
	task automatic send_byte(input logic [7:0] b, input int bt);
		lvl(1'b0, bt);
		for (int i = 0; i < 8; i++) begin
			lvl(b[i], bt);
		end
		lvl(1'b1, bt);
	endtask

	// Length in clocks of the next low run on the transmit line
	task automatic low_run(output int n);
		n = 0;
		while (line_in !== 1'b0) @(posedge clk);
		while (line_in === 1'b0) begin
			n++;
			@(posedge clk);
		end
	endtask

	// Decode one character; sampling at mid-bit tolerates a short first bit
	task automatic get_byte(input int bt, output logic [7:0] b);
		while (line_in !== 1'b0) @(posedge clk);
		repeat (bt + bt / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			b[i] = line_in;
			repeat (bt) @(posedge clk);
		end
	endtask
endmodule

// File: bench/uart_abd_tb.sv
// Self-checking bench for autobaud, wake on break and break transmission
`timescale 1ns/1ns

module uart_abd_tb
	import uart_abd_pkg::*;
;
	// Autobaud case: control word, bit time in clocks, expected divisor
	typedef struct {
		logic [7:0]  ctrl;
		int          bt;
		logic [15:0] div;
	} ab_row_s;

	logic       clk;
	logic       rst_n;
	axil_req_s  req;         // Bus master outputs
	axil_rsp_s  rsp;         // Slave answers
	logic       rx;          // Line from remote node
	logic       tx;          // Line to remote node
	int         num_errors;
	int         n_tests;
	int         lr;          // Measured low run
	logic [7:0] b;           // Decoded character
	logic [31:0] d;          // Read data
	logic [1:0]  r;          // Read response

	// Pairs 11, 01, 00, 10; two rows come after a break
	ab_row_s rows[4] = '{'{8'h31, 128, 16'h0021}, '{8'h23, 256, 16'h0011},
		'{8'h01, 1024, 16'h0011}, '{8'h13, 256, 16'h0011}};

	uart_abd uart_abd_inst (
		.clk          (clk),
		.rst_n        (rst_n),
		.bus_req      (req),
		.bus_rsp      (rsp),
		.receive_line (rx),
		.transmit_line(tx)
	);

	serial_node_model serial_node_model_inst (
		.clk     (clk),
		.line_out(rx),
		.line_in (tx)
	);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Verdict and end of run
	task automatic complete_run();
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	// Measured figures may land within a small phase window
	task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
		n_tests++;
		// Written so that an unknown value counts as a mismatch
		if ((g >= lo && g <= hi) !== 1'b1) begin
			$display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
			num_errors++;
		end
	endtask

	// Write: address and data offered together, bready held until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		req.awaddr  <= a;
		req.wdata   <= v;
		req.wstrb   <= 4'hf;
		req.bready  <= 1'b1;
		do @(posedge clk); while (rsp.awready !== 1'b1);
		req.awvalid <= 1'b0;
		req.wvalid  <= 1'b0;
		while (rsp.bvalid !== 1'b1) @(posedge clk);
		req.bready <= 1'b0;
	endtask

	// Read: data and response taken at the rvalid edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		while (rsp.rvalid !== 1'b1) @(posedge clk);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	// Hang guard, well beyond the expected run length
	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		complete_run();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		req = '0;
		num_errors = 0;
		n_tests = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			rd(STATUS_OFS);
			chk("idle before", 32'h1, d[STAT_IDLE]);
			wr(CTRL_OFS, {24'h0, rows[i].ctrl});
			if (rows[i].ctrl[CTRL_WUE]) begin
				serial_node_model_inst.lvl(1'b0, 20);
				rd(STATUS_OFS);
				chk("wake flag", 32'h1, d[STAT_RECEIVE_INT_FLAG]);
				rd(CTRL_OFS);
				chk("wake held", {24'h0, rows[i].ctrl}, d);
				serial_node_model_inst.lvl(1'b0, 13 * rows[i].bt);
				serial_node_model_inst.lvl(1'b1, 20);
				rd(CTRL_OFS);
				chk("wake clear", {24'h0, rows[i].ctrl & 8'hfd}, d);
				rd(RXDATA_OFS);
				rd(STATUS_OFS);
				chk("wake ack", 32'h0, d[STAT_RECEIVE_INT_FLAG]);
			end
			fork
				serial_node_model_inst.send_byte(8'h55, rows[i].bt);
				begin
					repeat (3 * rows[i].bt) @(posedge clk);
					rd(STATUS_OFS);
					chk("busy flags", 32'h0, d[1:0]);
				end
			join
			repeat (4) @(posedge clk);
			rd(DIVISOR_OFS);
			chk_rng("divisor", rows[i].div - 1, rows[i].div + 1, d);
			rd(CTRL_OFS);
			chk("ctrl done", {24'h0, rows[i].ctrl & 8'hfc}, d);
			rd(STATUS_OFS);
			chk("done flags", 32'hf, d[4:0]);
			rd(RXDATA_OFS);
			rd(STATUS_OFS);
			chk("flag ack", 32'h0, d[STAT_RECEIVE_INT_FLAG]);
			wr(STATUS_OFS, 32'h10);
		end
		// Break then preloaded sync; bit time is two ticks of four clocks
		wr(DIVISOR_OFS, 32'h1);
		wr(CTRL_OFS, 32'h3c);
		fork
			begin
				serial_node_model_inst.low_run(lr);
				serial_node_model_inst.get_byte(8, b);
			end
			begin
				wr(TXDATA_OFS, 32'ha5);
				wr(TXDATA_OFS, 32'h55);
				rd(CTRL_OFS);
				chk("break bit held", 32'h1, d[CTRL_SEND_BREAK]);
			end
		join
		chk_rng("break low", 100, 104, lr);
		chk("sync sent", 32'h55, b);
		rd(CTRL_OFS);
		chk("break bit clear", 32'h38, d);
		// Second reset in mid-run, then reset values and an unmapped place
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(CTRL_OFS);
		chk("ctrl reset", 32'h0, d);
		rd(DIVISOR_OFS);
		chk("divisor reset", {16'h0, DIV_RESET}, d);
		rd(TXDATA_OFS);
		chk("txdata read", 32'h0, d);
		rd(8'h14);
		chk("unmapped resp", {30'h0, RESP_DECERR}, r);
		// Read answer must stand while the master stalls rready
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr  <= STATUS_OFS;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		repeat (3) @(posedge clk);
		req.rready <= 1'b1;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
		chk("stalled read", 32'he, rsp.rdata);
		complete_run();
	end
endmodule
